// *** logic/sxs_exec.sv ***
/*
 Execution datapath for subtract, exclusive OR, nibble swap,
 direction load and sleep. Holds the accumulator, status flags and
 port direction registers. Assumes the sequencer presents one
 instruction per cycle on exec_valid and that the data memory takes
 file_write with file_wdata in the same cycle.
*/
// How it works
// - Literal subtract puts the literal minus the accumulator into the accumulator and updates the flags.
// - Literal subtract sets carry when accumulator <= literal, and digit carry likewise on low nibbles.
// - File subtract computes file minus accumulator with carry and digit carry from the same compares.
// - With destination bit 0 the result goes to the accumulator, with 1 back to the file register.
// - Subtract with borrow also takes away the inverted carry flag.
// - Nibble swap exchanges the two nibbles and leaves every flag unchanged.
// - Literal XOR writes accumulator XOR literal to the accumulator and updates only zero.
// - File XOR routes accumulator XOR file by the destination bit and updates only zero.
// - Direction load copies the accumulator to port A, B or C direction for operand 5, 6 or 7.
// - Sleep clears the power-down flag and sets the time-out flag.
// - Sleep clears the watchdog counter and its prescaler.
// - After sleep the core halts until a wake input arrives.
`timescale 1ns/1ps
module sxs_exec
   import sxs_pkg::*;
(
   input wire logic clk,
   input wire logic rst_b,
   input wire logic exec_valid,
   input wire sxs_op_type exec_op,
   input wire logic [7:0] literal,
   input wire logic [2:0] direction_sel,
   input wire logic dest_sel,
   input wire logic [7:0] file_rdata,
   input wire logic wake,
   output logic exec_ready,
   output logic file_write,
   output logic [7:0] file_wdata,
   output logic [7:0] acc,
   output logic carry_flag,
   output logic digit_carry_flag,
   output logic zero_flag,
   output logic timeout_flag,
   output logic powerdown_flag,
   output logic [7:0] port_a_direction,
   output logic [7:0] port_b_direction,
   output logic [7:0] port_c_direction,
   output logic sleeping,
   output logic [7:0] watchdog_counter
);
   // ==========================================================
   // State
   typedef struct packed {
      logic [7:0] acc;
      logic carry;
      logic digit_carry;
      logic zero;
      logic timeout;
      logic powerdown;
      logic [7:0] dir_a;
      logic [7:0] dir_b;
      logic [7:0] dir_c;
      logic sleeping;
      logic file_write;
      logic [7:0] file_wdata;
   } sxs_state_type;

   sxs_state_type state;
   sxs_state_type next_state;
   sxs_alu_if alu_bus ();
   logic go;
   logic wdt_clear;

   // ==========================================================
   // Arithmetic unit and watchdog
   sxs_alu u_alu (.bus(alu_bus));

   sxs_watchdog #(.PRESCALE_WIDTH(8)) u_wdt (
      .clk(clk),
      .rst_b(rst_b),
      .clear(wdt_clear),
      .run(!state.sleeping),
      .count(watchdog_counter)
   );

   function automatic logic sxs_is_file_op(input sxs_op_type op);
      sxs_is_file_op = (op == SXS_OP_FILE_SUB) || (op == SXS_OP_FILE_SUB_BORROW) ||
         (op == SXS_OP_NIBBLE_SWAP) || (op == SXS_OP_FILE_XOR);
   endfunction

   assign go = exec_valid && !state.sleeping;
   assign exec_ready = !state.sleeping;
   assign wdt_clear = go && (exec_op == SXS_OP_SLEEP);

   always_comb
   begin
      alu_bus.op = exec_op;
      alu_bus.acc = state.acc;
      alu_bus.carry_in = state.carry;
      alu_bus.operand = (exec_op == SXS_OP_LIT_SUB || exec_op == SXS_OP_LIT_XOR) ?
         literal : file_rdata;
   end

   // ==========================================================
   // Next state
   always_comb
   begin
      next_state = state;
      next_state.file_write = 1'b0;
      if (state.sleeping && wake)
         next_state.sleeping = 1'b0;
      if (go)
      begin
         unique case (exec_op)
            SXS_OP_LIT_SUB:
            begin
               next_state.acc = alu_bus.result;
               next_state.carry = alu_bus.carry;
               next_state.digit_carry = alu_bus.digit_carry;
               next_state.zero = alu_bus.zero;
            end
            SXS_OP_FILE_SUB, SXS_OP_FILE_SUB_BORROW:
            begin
               next_state.carry = alu_bus.carry;
               next_state.digit_carry = alu_bus.digit_carry;
               next_state.zero = alu_bus.zero;
            end
            SXS_OP_LIT_XOR:
            begin
               next_state.acc = alu_bus.result;
               next_state.zero = alu_bus.zero;
            end
            SXS_OP_FILE_XOR:
               next_state.zero = alu_bus.zero;
            SXS_OP_DIRECTION_LOAD:
            begin
               if (direction_sel == SXS_DIR_PORT_A)
                  next_state.dir_a = state.acc;
               if (direction_sel == SXS_DIR_PORT_B)
                  next_state.dir_b = state.acc;
               if (direction_sel == SXS_DIR_PORT_C)
                  next_state.dir_c = state.acc;
            end
            SXS_OP_SLEEP:
            begin
               next_state.powerdown = 1'b0;
               next_state.timeout = 1'b1;
               next_state.sleeping = 1'b1;
            end
            default:
               next_state = next_state;
         endcase
         if (sxs_is_file_op(exec_op))
         begin
            if (dest_sel == SXS_DEST_FILE)
            begin
               next_state.file_write = 1'b1;
               next_state.file_wdata = alu_bus.result;
            end
            else
               next_state.acc = alu_bus.result;
         end
      end
   end

   always_ff @(posedge clk)
   begin
      if (!rst_b)
      begin
         state <= '0;
         state.acc <= SXS_ACC_RESET;
         state.timeout <= SXS_TIMEOUT_RESET;
         state.powerdown <= SXS_POWERDOWN_RESET;
         state.dir_a <= SXS_DIR_RESET;
         state.dir_b <= SXS_DIR_RESET;
         state.dir_c <= SXS_DIR_RESET;
      end
      else
         state <= next_state;
   end

   // ==========================================================
   // Outputs
   assign file_write = state.file_write;
   assign file_wdata = state.file_wdata;
   assign acc = state.acc;
   assign carry_flag = state.carry;
   assign digit_carry_flag = state.digit_carry;
   assign zero_flag = state.zero;
   assign timeout_flag = state.timeout;
   assign powerdown_flag = state.powerdown;
   assign port_a_direction = state.dir_a;
   assign port_b_direction = state.dir_b;
   assign port_c_direction = state.dir_c;
   assign sleeping = state.sleeping;

   // ==========================================================
   // Checks
   property p_lit_sub;
      @(posedge clk) disable iff (!rst_b)
      (go && exec_op == SXS_OP_LIT_SUB) |=>
         acc == 8'($past(literal) - $past(state.acc));
   endproperty
   a_lit_sub: assert property (p_lit_sub) else $error("literal subtract wrong");

   property p_lit_carry;
      @(posedge clk) disable iff (!rst_b)
      (go && exec_op == SXS_OP_LIT_SUB) |=>
         carry_flag == ($past(state.acc) <= $past(literal)) &&
         digit_carry_flag == ($past(state.acc[3:0]) <= $past(literal[3:0]));
   endproperty
   a_lit_carry: assert property (p_lit_carry) else $error("subtract carry wrong");

   property p_file_sub;
      @(posedge clk) disable iff (!rst_b)
      (go && exec_op == SXS_OP_FILE_SUB && dest_sel == SXS_DEST_FILE) |=>
         file_write && file_wdata == 8'($past(file_rdata) - $past(state.acc)) &&
         carry_flag == ($past(state.acc) <= $past(file_rdata));
   endproperty
   a_file_sub: assert property (p_file_sub) else $error("file subtract wrong");

   property p_dest_acc;
      @(posedge clk) disable iff (!rst_b)
      (go && exec_op == SXS_OP_FILE_XOR && dest_sel == SXS_DEST_ACC) |=>
         !file_write && acc == ($past(state.acc) ^ $past(file_rdata));
   endproperty
   a_dest_acc: assert property (p_dest_acc) else $error("destination routing wrong");

   property p_borrow;
      @(posedge clk) disable iff (!rst_b)
      (go && exec_op == SXS_OP_FILE_SUB_BORROW && dest_sel == SXS_DEST_ACC) |=>
         acc == 8'($past(file_rdata) - $past(state.acc) - {7'h00, !$past(state.carry)});
   endproperty
   a_borrow: assert property (p_borrow) else $error("borrow subtract wrong");

   property p_swap;
      @(posedge clk) disable iff (!rst_b)
      (go && exec_op == SXS_OP_NIBBLE_SWAP) |=>
         $stable({carry_flag, digit_carry_flag, zero_flag});
   endproperty
   a_swap: assert property (p_swap) else $error("swap changed flags");

   property p_lit_xor;
      @(posedge clk) disable iff (!rst_b)
      (go && exec_op == SXS_OP_LIT_XOR) |=>
         acc == ($past(state.acc) ^ $past(literal)) && $stable(carry_flag) &&
         zero_flag == (acc == 8'h00);
   endproperty
   a_lit_xor: assert property (p_lit_xor) else $error("literal xor wrong");

   property p_dir;
      @(posedge clk) disable iff (!rst_b)
      (go && exec_op == SXS_OP_DIRECTION_LOAD && direction_sel == SXS_DIR_PORT_B) |=>
         port_b_direction == $past(state.acc) && $stable(port_a_direction);
   endproperty
   a_dir: assert property (p_dir) else $error("direction load wrong");

   property p_file_digit;
      @(posedge clk) disable iff (!rst_b)
      (go && exec_op == SXS_OP_FILE_SUB) |=>
         digit_carry_flag == ($past(state.acc[3:0]) <= $past(file_rdata[3:0]));
   endproperty
   a_file_digit: assert property (p_file_digit) else $error("file digit carry wrong");

   property p_file_xor;
      @(posedge clk) disable iff (!rst_b)
      (go && exec_op == SXS_OP_FILE_XOR && dest_sel == SXS_DEST_FILE) |=>
         file_write && file_wdata == ($past(state.acc) ^ $past(file_rdata)) &&
         $stable(acc) && $stable({carry_flag, digit_carry_flag});
   endproperty
   a_file_xor: assert property (p_file_xor) else $error("file xor wrong");

   property p_borrow_zero;
      @(posedge clk) disable iff (!rst_b)
      (go && exec_op == SXS_OP_FILE_SUB_BORROW && dest_sel == SXS_DEST_FILE) |=>
         file_write && zero_flag == (file_wdata == 8'h00) && $stable(acc);
   endproperty
   a_borrow_zero: assert property (p_borrow_zero) else $error("borrow zero wrong");

   property p_dir_other;
      @(posedge clk) disable iff (!rst_b)
      (go && exec_op == SXS_OP_DIRECTION_LOAD && direction_sel < SXS_DIR_PORT_A) |=>
         $stable({port_a_direction, port_b_direction, port_c_direction}) &&
         $stable({carry_flag, digit_carry_flag, zero_flag});
   endproperty
   a_dir_other: assert property (p_dir_other) else $error("direction load misrouted");

   sequence s_sleep_taken;
      go && exec_op == SXS_OP_SLEEP;
   endsequence

   property p_sleep;
      @(posedge clk) disable iff (!rst_b)
      s_sleep_taken |=> !powerdown_flag && timeout_flag && sleeping &&
         watchdog_counter == 8'h00;
   endproperty
   a_sleep: assert property (p_sleep) else $error("sleep entry wrong");

   property p_halt;
      @(posedge clk) disable iff (!rst_b)
      (sleeping && !wake) |=> sleeping && $stable(acc) && !file_write;
   endproperty
   a_halt: assert property (p_halt) else $error("executed while asleep");
endmodule

// *** logic/sxs_pkg.sv ***
/*
 Package for the subtract/xor/swap/sleep execution datapath.
 Holds operation codes, direction select codes and reset values.
 Assumes a single 40 MHz instruction clock.
*/
package sxs_pkg;
   // ==========================================================
   // Operation select
   typedef enum logic [3:0] {
      SXS_OP_NONE = 4'h0,
      SXS_OP_LIT_SUB = 4'h1,
      SXS_OP_FILE_SUB = 4'h2,
      SXS_OP_FILE_SUB_BORROW = 4'h3,
      SXS_OP_NIBBLE_SWAP = 4'h4,
      SXS_OP_LIT_XOR = 4'h5,
      SXS_OP_FILE_XOR = 4'h6,
      SXS_OP_DIRECTION_LOAD = 4'h7,
      SXS_OP_SLEEP = 4'h8
   } sxs_op_type;

   // ==========================================================
   // Direction load operands
   localparam logic [2:0] SXS_DIR_PORT_A = 3'h5;
   localparam logic [2:0] SXS_DIR_PORT_B = 3'h6;
   localparam logic [2:0] SXS_DIR_PORT_C = 3'h7;

   // ==========================================================
   // Destination select values
   localparam logic SXS_DEST_ACC = 1'b0;
   localparam logic SXS_DEST_FILE = 1'b1;

   // ==========================================================
   // Reset values
   localparam logic [7:0] SXS_ACC_RESET = 8'h00;
   localparam logic [7:0] SXS_DIR_RESET = 8'hff;
   localparam logic [7:0] SXS_WDT_CLEAR = 8'h00;
   localparam logic SXS_TIMEOUT_RESET = 1'b1;
   localparam logic SXS_POWERDOWN_RESET = 1'b1;
endpackage

// *** logic/sxs_alu_if.sv ***
/*
 Interface carrying operands and results between the execution
 datapath and its arithmetic unit. Assumes combinational use.
*/
`timescale 1ns/1ps
interface sxs_alu_if;
   import sxs_pkg::*;
   sxs_op_type op;
   logic [7:0] acc;
   logic [7:0] operand;
   logic carry_in;
   logic [7:0] result;
   logic carry;
   logic digit_carry;
   logic zero;
   modport core (output op, output acc, output operand, output carry_in,
      input result, input carry, input digit_carry, input zero);
   modport alu (input op, input acc, input operand, input carry_in,
      output result, output carry, output digit_carry, output zero);
endinterface

// *** logic/sxs_alu.sv ***
/*
 Combinational arithmetic unit: subtract, subtract with borrow,
 exclusive OR and nibble swap. Assumes operands are stable.
*/
`timescale 1ns/1ps
module sxs_alu
   import sxs_pkg::*;
(
   sxs_alu_if.alu bus
);
   // ==========================================================
   // Subtract helper
   function automatic logic [8:0] sxs_sub(input logic [7:0] a, input logic [7:0] b,
      input logic cin);
      sxs_sub = {1'b0, a} + {1'b0, ~b} + {8'h00, cin};
   endfunction

   function automatic logic sxs_nib(input logic [3:0] a, input logic [3:0] b,
      input logic cin);
      logic [4:0] s;
      s = {1'b0, a} + {1'b0, ~b} + {4'h0, cin};
      sxs_nib = s[4];
   endfunction

   logic [8:0] diff;
   logic cin;

   always_comb
   begin
      cin = (bus.op == SXS_OP_FILE_SUB_BORROW) ? bus.carry_in : 1'b1;
      diff = sxs_sub(bus.operand, bus.acc, cin);
      bus.carry = diff[8];
      bus.digit_carry = sxs_nib(bus.operand[3:0], bus.acc[3:0], cin);
      unique case (bus.op)
         SXS_OP_LIT_XOR, SXS_OP_FILE_XOR:
            bus.result = bus.acc ^ bus.operand;
         SXS_OP_NIBBLE_SWAP:
            bus.result = {bus.operand[3:0], bus.operand[7:4]};
         default:
            bus.result = diff[7:0];
      endcase
      bus.zero = (bus.result == 8'h00);
   end
endmodule

// *** logic/sxs_watchdog.sv ***
/*
 Watchdog counter and prescaler. Cleared by the sleep strobe.
 Assumes one clock; counts only while not asleep.
*/
`timescale 1ns/1ps
module sxs_watchdog
   import sxs_pkg::*;
#(
   parameter int PRESCALE_WIDTH = 8
)
(
   input wire logic clk,
   input wire logic rst_b,
   input wire logic clear,
   input wire logic run,
   output logic [7:0] count
);
   typedef struct packed {
      logic [PRESCALE_WIDTH-1:0] prescaler;
      logic [7:0] counter;
   } sxs_wdt_type;

   sxs_wdt_type state;
   sxs_wdt_type next_state;

   always_comb
   begin
      next_state = state;
      if (clear)
      begin
         next_state.counter = SXS_WDT_CLEAR;
         next_state.prescaler = '0;
      end
      else if (run)
      begin
         next_state.prescaler = state.prescaler + 1'b1;
         if (&state.prescaler)
            next_state.counter = state.counter + 8'h01;
      end
   end

   always_ff @(posedge clk)
   begin
      if (!rst_b)
         state <= '0;
      else
         state <= next_state;
   end

   assign count = state.counter;
endmodule

// *** dv/sxs_mem_model.sv ***
/*
 Data memory file model facing the execution datapath.
 Assumes the address stands while exec_valid is high and that the
 write pulse follows the taking edge by one cycle.
*/
`timescale 1ns/1ps
module sxs_mem_model
(
   input wire logic clk,
   input wire logic take,
   input wire logic [6:0] addr,
   input wire logic file_write,
   input wire logic [7:0] file_wdata,
   output logic [7:0] file_rdata
);
   logic [7:0] mem [128];
   logic [6:0] waddr;
   initial
   begin
      for (int i = 0; i < 128; i++)
         mem[i] = 8'(i * 37 + 3);
   end
   assign file_rdata = mem[addr];
   always @(posedge clk)
   begin
      if (take)
         waddr <= addr;
      if (file_write)
         mem[waddr] <= file_wdata;
   end
endmodule

// *** dv/subtract_xor_swap_sleep_exec_tb.sv ***
/*
 Self-checking bench for the execution datapath.
 Assumes sxs_pkg and the memory model are compiled first.
*/
`timescale 1ns/1ps
module subtract_xor_swap_sleep_exec_tb;
   import sxs_pkg::*;
   logic clk = 0, rst_b = 0, exec_valid = 0, dest_sel = 0, wake = 0;
   sxs_op_type exec_op = SXS_OP_NONE;
   logic [7:0] literal = 8'h00;
   logic [2:0] direction_sel = 3'h0;
   logic [6:0] addr = 7'h00;
   logic [7:0] file_rdata, file_wdata, acc, pa, pb, pc, wdc;
   logic exec_ready, file_write, cf, dcf, zf, tof, pdf, sleeping;
   int errors = 0, checks = 0, cyc = 0;
   logic [7:0] ea = 8'h00, ed [3] = '{8'hff, 8'hff, 8'hff};
   logic ec = 0, edc = 0, ez = 0, ewr = 0;
   logic [7:0] ewd;
   sxs_op_type fops [4] = '{SXS_OP_FILE_SUB, SXS_OP_FILE_SUB_BORROW,
      SXS_OP_NIBBLE_SWAP, SXS_OP_FILE_XOR};
   logic [7:0] tab [8] = '{8'h05, 8'h05, 8'h06, 8'h05, 8'h10, 8'h0f, 8'h0f, 8'h10};

   sxs_exec i_sxs_exec (.clk(clk), .rst_b(rst_b), .exec_valid(exec_valid),
      .exec_op(exec_op), .literal(literal), .direction_sel(direction_sel),
      .dest_sel(dest_sel), .file_rdata(file_rdata), .wake(wake),
      .exec_ready(exec_ready), .file_write(file_write), .file_wdata(file_wdata),
      .acc(acc), .carry_flag(cf), .digit_carry_flag(dcf), .zero_flag(zf),
      .timeout_flag(tof), .powerdown_flag(pdf), .port_a_direction(pa),
      .port_b_direction(pb), .port_c_direction(pc), .sleeping(sleeping),
      .watchdog_counter(wdc));
   sxs_mem_model i_sxs_mem_model (.clk(clk), .take(exec_valid), .addr(addr),
      .file_write(file_write), .file_wdata(file_wdata), .file_rdata(file_rdata));

   // ==========================================================
   // Clock and cycle ceiling
   always #12.5 clk = ~clk;
   always @(posedge clk)
   begin
      cyc <= cyc + 1;
      if (cyc == 3000)
      begin
         errors++;
         test_done;
      end
   end

   // ==========================================================
   // Checking helpers
   task automatic chk(input logic [39:0] g, input logic [39:0] e);
      checks++;
      if (g !== e)
      begin
         errors++;
         $display("ERROR t=%0t got=%h exp=%h", $time, g, e);
      end
   endtask

   task automatic chk_state;
      chk({acc, pa, pb, pc, 4'h0, file_write, cf, dcf, zf},
         {ea, ed[0], ed[1], ed[2], 4'h0, ewr, ec, edc, ez});
      if (ewr)
         chk({32'h0, file_wdata}, {32'h0, ewd});
   endtask

   task automatic chk_power(input logic [3:0] e);
      chk({36'h0, tof, pdf, sleeping, exec_ready}, {36'h0, e});
   endtask

   // ==========================================================
   // One instruction: expectation, drive, compare
   task automatic run(input sxs_op_type op, input logic [7:0] k, input logic [2:0] ds,
      input logic d, input logic [6:0] a);
      logic [7:0] f, res;
      logic [8:0] r;
      logic [4:0] t;
      logic nb;
      @(posedge clk);
      #1;
      f = i_sxs_mem_model.mem[a];
      nb = (op == SXS_OP_FILE_SUB_BORROW) ? ~ec : 1'b0;
      ewr = 1'b0;
      res = ea;
      if (op == SXS_OP_LIT_SUB || op == SXS_OP_LIT_XOR)
         f = k;
      case (op)
         SXS_OP_LIT_SUB, SXS_OP_FILE_SUB, SXS_OP_FILE_SUB_BORROW:
         begin
            r = {1'b0, f} - {1'b0, ea} - {8'h00, nb};
            t = {1'b0, f[3:0]} - {1'b0, ea[3:0]} - {4'h0, nb};
            res = r[7:0];
            ec = ~r[8];
            edc = ~t[4];
            ez = (res == 8'h00);
         end
         SXS_OP_LIT_XOR, SXS_OP_FILE_XOR:
         begin
            res = ea ^ f;
            ez = (res == 8'h00);
         end
         SXS_OP_NIBBLE_SWAP: res = {f[3:0], f[7:4]};
         SXS_OP_DIRECTION_LOAD: if (ds >= 3'h5) ed[ds - 3'h5] = ea;
         default: ;
      endcase
      if (op == SXS_OP_LIT_SUB || op == SXS_OP_LIT_XOR || (op inside {fops} && !d))
         ea = res;
      else if (op inside {fops})
      begin
         ewr = 1'b1;
         ewd = res;
      end
      exec_op <= op;
      literal <= k;
      direction_sel <= ds;
      dest_sel <= d;
      addr <= a;
      exec_valid <= 1'b1;
      @(posedge clk);
      #1;
      exec_valid <= 1'b0;
      chk_state;
   endtask

   task automatic set_acc(input logic [7:0] v);
      run(SXS_OP_LIT_XOR, ea ^ v, 3'h0, 1'b0, 7'h00);
   endtask

   task automatic test_done;
      $display("checks=%0d errors=%0d", checks, errors);
      if (errors == 0 && checks > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask

   // ==========================================================
   // Test sequence
   initial
   begin
      repeat (12) @(posedge clk);
      rst_b <= 1'b1;
      #1;
      chk_state;
      chk_power(4'b1101);
      $display("reset test done");
      for (int i = 0; i < 8; i += 2)
      begin
         set_acc(tab[i]);
         run(SXS_OP_LIT_SUB, tab[i + 1], 3'h0, 1'b0, 7'h00);
      end
      $display("literal subtract test done");
      for (int i = 0; i < 16; i++)
         run(fops[i % 4], 8'h00, 3'h0, i[2], 7'(i % 6));
      set_acc(8'h00);
      run(SXS_OP_FILE_SUB_BORROW, 8'h00, 3'h0, 1'b0, 7'h09);
      set_acc(i_sxs_mem_model.mem[9]);
      run(SXS_OP_FILE_XOR, 8'h00, 3'h0, 1'b0, 7'h09);
      run(SXS_OP_LIT_XOR, 8'h3c, 3'h0, 1'b0, 7'h00);
      $display("file operation test done");
      for (int i = 4; i < 8; i++)
      begin
         set_acc(8'(i * 17));
         run(SXS_OP_DIRECTION_LOAD, 8'h00, 3'(i), 1'b0, 7'h00);
      end
      run(SXS_OP_NONE, 8'h00, 3'h0, 1'b1, 7'h02);
      $display("direction load test done");
      repeat (512) @(posedge clk);
      #1;
      chk({39'h0, wdc != 8'h00}, 40'h1);
      run(SXS_OP_SLEEP, 8'h00, 3'h0, 1'b0, 7'h00);
      chk_power(4'b1010);
      chk({32'h0, wdc}, {32'h0, SXS_WDT_CLEAR});
      @(posedge clk);
      #1;
      exec_op <= SXS_OP_LIT_XOR;
      literal <= 8'h81;
      exec_valid <= 1'b1;
      repeat (3) @(posedge clk);
      #1;
      exec_valid <= 1'b0;
      chk_state;
      chk_power(4'b1010);
      chk({32'h0, wdc}, {32'h0, SXS_WDT_CLEAR});
      wake <= 1'b1;
      @(posedge clk);
      #1;
      wake <= 1'b0;
      chk_power(4'b1001);
      run(SXS_OP_LIT_XOR, 8'h81, 3'h0, 1'b0, 7'h00);
      $display("sleep test done");
      test_done;
   end
endmodule
